/* File: sar_adc_sequencer.sv */
// Purpose: control and sequencing of a 10-bit successive-approximation converter
// Assumes: sleep and special event come from logic on clk_i; comparator and RC clock are pins
// Notes: the analog array is outside; this block drives its sample, discharge and trial code
//
// The strobed register port and the address map are this design's own decisions.
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // system
  input wire logic sleep_i,
  input wire logic special_event_i,
  output logic timer_reset_o,
  output logic wake_o,
  // analog array
  input wire logic rc_clk_i,
  input wire logic cmp_i,
  output logic [3:0] channel_o,
  output logic sample_o,
  output logic discharge_o,
  output logic converting_o,
  output logic module_on_o,
  output logic [9:0] sar_code_o
);
  sar_adc_pkg::state_type state, next_state;
  logic enable, go_done, flag, irq_en, format, sleep_off;
  logic [3:0] chs;
  logic [2:0] acq_sel, clk_sel;
  logic [9:0] result, work;
  logic [5:0] div_cnt;
  logic [4:0] tad_cnt;
  logic [3:0] cyc_cnt;
  logic rc_m, rc_s, rc_d, cmp_m, cmp_s;
  logic next_go, next_flag;

  // decoded strobes
  wire wr_c0 = wr_i && addr_i == `OFS_CTRL0;
  wire wr_c2 = wr_i && addr_i == `OFS_CTRL2;
  wire wr_fl = wr_i && addr_i == `OFS_FLAGS;
  wire rc_sel = clk_sel[1:0] == `RC_SELECT;
  // non-RC clock cannot survive sleep
  wire sleep_kill = sleep_i && !rc_sel;
  wire module_on = enable && !sleep_kill && !sleep_off;
  wire busy = state != sar_adc_pkg::st_idle && state != sar_adc_pkg::st_dis;

  // divider: /2 shifted by a weight made from the select code
  wire [2:0] div_shift = {clk_sel[1:0], 1'b0} + {2'h0, clk_sel[2]};
  wire [5:0] div_max = 6'((7'h02 << div_shift) - 7'h01);
  wire rc_edge = rc_s && !rc_d;
  wire tad_tick = rc_sel ? rc_edge : div_cnt >= div_max;

  // acquisition length in clock periods per code
  wire [4:0] acq_tads = acq_sel == 3'h0 ? 5'h00 :
                        acq_sel == 3'h1 ? 5'h02 :
                        acq_sel == 3'h2 ? 5'h04 :
                        acq_sel == 3'h3 ? 5'h06 :
                        acq_sel == 3'h4 ? 5'h08 :
                        acq_sel == 3'h5 ? 5'h0c :
                        acq_sel == 3'h6 ? 5'h10 : 5'h14;
  // one instruction for manual mode, one more with the RC clock
  wire [3:0] start_cyc = (acq_sel == 3'h0 ? `INSTR_CYC : 4'h0) +
                         (rc_sel ? `INSTR_CYC : 4'h0);
  wire start_ok = module_on && state == sar_adc_pkg::st_idle;
  // rejecting go in the enabling write keeps the array settled
  wire sw_start = wr_c0 && wdata_i[`CTRL0_GO] && enable && start_ok;
  wire hw_start = special_event_i && start_ok;
  wire sw_abort = wr_c0 && !wdata_i[`CTRL0_GO] && busy;
  wire done = state == sar_adc_pkg::st_conv && tad_tick && tad_cnt == `CONV_TADS - 5'h01;
  wire tad_last = tad_tick && tad_cnt == `REST_TADS - 5'h01;
  // one-hot trial bit walks down from bit 9, one place per period
  wire [9:0] trial_bit = 10'h200 >> (tad_cnt - 5'h01);

  // result byte formatting
  wire [7:0] res_hi = format ? {6'h00, result[9:8]} : result[9:2];
  wire [7:0] res_lo = format ? result[7:0] : {result[1:0], 6'h00};
  wire [7:0] rd_mux = addr_i == `OFS_CTRL0 ? {2'h0, chs, go_done, enable} :
                      addr_i == `OFS_CTRL2 ? {format, 1'b0, acq_sel, clk_sel} :
                      addr_i == `OFS_RES_HI ? res_hi :
                      addr_i == `OFS_RES_LO ? res_lo :
                      addr_i == `OFS_FLAGS ? {6'h00, irq_en, flag} : 8'h00;

  // go bit: hardware completion and kill clear it
  always_comb begin
    next_go = go_done;
    if (sw_start || hw_start) begin
      next_go = 1'b1;
    end else if (done || !module_on || sw_abort) begin
      next_go = 1'b0;
    end
  end

  // a completion in the clearing cycle is kept
  always_comb begin
    next_flag = flag;
    if (wr_fl) begin
      next_flag = wdata_i[`FLAGS_DONE];
    end
    if (done) begin
      next_flag = 1'b1;
    end
  end

  // phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      sar_adc_pkg::st_idle: begin
        if (go_done) begin
          next_state = sar_adc_pkg::st_start;
        end
      end
      sar_adc_pkg::st_start: begin
        if (cyc_cnt >= start_cyc) begin
          next_state = acq_tads == 5'h00 ? sar_adc_pkg::st_conv : sar_adc_pkg::st_acq;
        end
      end
      sar_adc_pkg::st_acq: begin
        if (tad_tick && tad_cnt == acq_tads - 5'h01) begin
          next_state = sar_adc_pkg::st_conv;
        end
      end
      sar_adc_pkg::st_conv: begin
        if (done) begin
          next_state = sar_adc_pkg::st_dis;
        end
      end
      sar_adc_pkg::st_dis: begin
        if (tad_last) begin
          next_state = sar_adc_pkg::st_idle;
        end
      end
      default: next_state = sar_adc_pkg::st_idle;
    endcase
    if (busy && !go_done) begin
      next_state = sar_adc_pkg::st_dis;
    end
    if (!module_on) begin
      next_state = sar_adc_pkg::st_idle;
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    rc_m <= rc_clk_i;
    rc_s <= rc_m;
    rc_d <= rc_s;
    cmp_m <= cmp_i;
    cmp_s <= cmp_m;
  end

  // software-visible registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= 1'b0;
      chs <= 4'h0;
      format <= 1'b0;
      acq_sel <= 3'h0;
      clk_sel <= 3'h0;
      irq_en <= 1'b0;
      go_done <= 1'b0;
      flag <= 1'b0;
    end else begin
      go_done <= next_go;
      flag <= next_flag;
      if (wr_c0) begin
        enable <= wdata_i[`CTRL0_ENABLE];
        chs <= wdata_i[5:2];
      end
      if (wr_c2) begin
        format <= wdata_i[`CTRL2_FORMAT];
        acq_sel <= wdata_i[5:3];
        clk_sel <= wdata_i[2:0];
      end
      if (wr_fl) begin
        irq_en <= wdata_i[`FLAGS_IRQ_EN];
      end
    end
  end

  // phase state and counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sar_adc_pkg::st_idle;
      div_cnt <= 6'h00;
      tad_cnt <= 5'h00;
      cyc_cnt <= 4'h0;
    end else begin
      state <= next_state;
      // restart the divider on every phase change so each divider-clocked phase is whole periods; RC-clocked phases start on a free-running edge
      div_cnt <= (tad_tick || next_state != state) ? 6'h00 : div_cnt + 6'h01;
      cyc_cnt <= state == sar_adc_pkg::st_start ? cyc_cnt + 4'h1 : 4'h0;
      if (next_state != state) begin
        tad_cnt <= 5'h00;
      end else if (tad_tick) begin
        tad_cnt <= tad_cnt + 5'h01;
      end
    end
  end

  // trial register: first period settles, then one bit per period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work <= 10'h000;
      result <= 10'h000;
    end else if (state != sar_adc_pkg::st_conv) begin
      work <= 10'h200;
    end else if (tad_tick && tad_cnt != 5'h00) begin
      work <= (work & ~trial_bit) | ({10{cmp_s}} & trial_bit) | (trial_bit >> 1);
      if (done) begin
        result <= {work[9:1], cmp_s};
      end
    end
  end

  // sleep power-down: cleared once the device leaves sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_off <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= done && sleep_i && irq_en;
      if (!sleep_i) begin
        sleep_off <= 1'b0;
      end else if (done && !irq_en) begin
        sleep_off <= 1'b1;
      end
    end
  end

  // registered outputs; analog controls lag the phase by one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      timer_reset_o <= 1'b0;
      channel_o <= 4'h0;
      sample_o <= 1'b0;
      discharge_o <= 1'b0;
      converting_o <= 1'b0;
      module_on_o <= 1'b0;
      sar_code_o <= 10'h000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      timer_reset_o <= hw_start;
      channel_o <= chs;
      sample_o <= module_on && (state == sar_adc_pkg::st_idle || state == sar_adc_pkg::st_start
                  || state == sar_adc_pkg::st_acq);
      discharge_o <= state == sar_adc_pkg::st_dis;
      converting_o <= state == sar_adc_pkg::st_conv;
      module_on_o <= module_on;
      sar_code_o <= work;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_done_clears_go: assert property (done && !sw_start |=> !go_done) else $error("go stayed set");
  a_done_sets_flag: assert property (done ##1 1'b1 |-> flag) else $error("flag not set");
  a_abort_keeps_res: assert property (sw_abort && !done |=> $stable(result) && $stable(flag))
    else $error("result changed on abort");
  a_off_goes_idle: assert property (!module_on |=> state == sar_adc_pkg::st_idle)
    else $error("disabled but active");
  a_conv_eleven: assert property (done |-> work[0] && tad_cnt == 5'h0a) else $error("wrong length");
  a_rest_two_tad: assert property (state == sar_adc_pkg::st_conv && done && module_on
    |=> state == sar_adc_pkg::st_dis && tad_cnt == 5'h00) else $error("no rest phase");
  a_sleep_kill_off: assert property (sleep_i && !rc_sel && busy |=> !go_done && state ==
    sar_adc_pkg::st_idle ##1 !module_on_o) else $error("sleep abort failed");
  a_event_sets_go: assert property (hw_start |=> go_done && timer_reset_o)
    else $error("event start failed");
  a_start_wait: assert property (state == sar_adc_pkg::st_idle && go_done && acq_sel == 3'h0
    && !rc_sel && module_on |=> state == sar_adc_pkg::st_start [*4])
    else $error("start wait wrong");
endmodule
`default_nettype wire

/* File: sar_adc_defines.svh */
// Purpose: offsets, fields, clock select code and timing counts of the converter
// Assumes: 25 MHz system clock, one instruction is four system clocks
// Notes: register offsets are byte indices on the plain register port
// Overview of operation
// - clock select picks divider or RC clock
// - result justified left or right by format
// - converter works only while enable is set
// - go starts conversion or programmed acquisition first
// - acquisition code 010 gives four clock periods
// - zero acquisition starts one instruction after go
// - completion clears go, sets flag, loads result
// - capacitor array discharged after every sample
// - software clear of go abandons, result kept
// - reset clears registers, stops any conversion
// - two clock periods wait before next acquisition
// - sleep conversion needs RC, one extra instruction
// - sleep completion wakes or turns module off
// - sleep with non-RC clock aborts, module off
// - special event sets go, resets timer
// - a conversion takes eleven clock periods
// - acquisition code 000 is manual, reset value
// - sampling resumes after conversion, no phase indication
// - flag set every conversion, cleared by software
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
`define OFS_CTRL0 3'h0
`define OFS_CTRL2 3'h1
`define OFS_RES_HI 3'h2
`define OFS_RES_LO 3'h3
`define OFS_FLAGS 3'h4
`define CTRL0_ENABLE 0
`define CTRL0_GO 1
`define CTRL2_FORMAT 7
`define FLAGS_DONE 0
`define FLAGS_IRQ_EN 1
`define CLK_NS 40
`define INSTR_NS 160
`define INSTR_CYC 4'((`INSTR_NS + `CLK_NS - 1) / `CLK_NS)
`define CONV_TADS 5'h0b
`define REST_TADS 5'h02
`define RC_SELECT 2'h3
`endif

/* File: sar_adc_pkg.sv */
// Purpose: types shared by the converter sequencer
// Assumes: nothing beyond the defines header
// Notes: phase codes left to the tools
package sar_adc_pkg;
  typedef enum logic [2:0] {st_idle, st_start, st_acq, st_conv, st_dis} state_type;
endpackage

/* File: tb_top.sv */
// Purpose: self-checking bench for the converter sequencer through its register port
// Assumes: comparator held constant per conversion, rc clock free-running and unrelated to clk_i
// Notes: monitors count phase lengths at the falling edge, where outputs have settled
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // stimulus and observed signals
  logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sleep_i = 1'b0;
  logic special_event_i = 1'b0, rc_clk_i = 1'b0, cmp_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, d;
  logic timer_reset_o, wake_o, sample_o, discharge_o, converting_o, module_on_o;
  logic [3:0] channel_o;
  logic [9:0] sar_code_o;
  logic [2:0] cs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int n_mismatch = 0, checks_done = 0, n_conv, n_dis, n_wake, n_tr, lat, seen, i, l0;
  sar_adc_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .special_event_i(special_event_i),
    .timer_reset_o(timer_reset_o), .wake_o(wake_o), .rc_clk_i(rc_clk_i), .cmp_i(cmp_i), .channel_o(channel_o),
    .sample_o(sample_o), .discharge_o(discharge_o), .converting_o(converting_o), .module_on_o(module_on_o),
    .sar_code_o(sar_code_o));
  // clocks; rc period of 10.5 system clocks keeps its phase drifting
  always #20 clk_i = ~clk_i;
  always #210 rc_clk_i = ~rc_clk_i;
  // phase monitors, sampled away from the launching edge
  always @(negedge clk_i) begin
    if (converting_o) n_conv++;
    if (discharge_o) n_dis++;
    if (wake_o) n_wake++;
    if (timer_reset_o) n_tr++;
    if (converting_o) seen = 1;
    if (!seen) lat++;
  end
  task clr;
    n_conv = 0; n_dis = 0; n_wake = 0; n_tr = 0; lat = 0; seen = 0;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // enabling and starting are always separate writes
  task go(input logic [7:0] c2);
    wr(`OFS_CTRL2, c2);
    wr(`OFS_CTRL0, 8'h15);
    clr;
    wr(`OFS_CTRL0, 8'h17);
  endtask
  // bounded wait until a conversion or abort has passed its rest phase
  task settle;
    int k;
    for (k = 0; k < 6000; k++) begin
      @(negedge clk_i);
      if ((n_conv + n_dis) > 0 && !converting_o && !discharge_o) break;
    end
    if (k == 6000) n_mismatch++;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog, about fifteen times the expected run
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_CTRL0, d); check(d, 8'h00);
    rd(`OFS_CTRL2, d); check(d, 8'h00);
    rd(`OFS_FLAGS, d); check(d, 8'h00);
    rd(3'h5, d); check(d, 8'h00);
    // go in the enabling write must not start anything
    wr(`OFS_CTRL0, 8'h03); rd(`OFS_CTRL0, d); check(d & 8'h02, 8'h00);
    wr(`OFS_CTRL0, 8'h00); clr; wr(`OFS_CTRL0, 8'h02);
    repeat (40) @(negedge clk_i);
    check(n_conv, 0);
    check(module_on_o, 1'b0);
    // every divider, right justified, all trial bits kept
    for (i = 0; i < 6; i++) begin
      go({5'h10, cs[i]});
      settle;
      if (i == 0) l0 = lat;
      check(n_conv, 11 * (2 << i));
      check(n_dis, 2 * (2 << i));
    end
    check(channel_o, 4'h5);
    check(sample_o, 1'b1);
    check(sar_code_o, 16'h0200);
    check((l0 >= 5 && l0 <= 10), 1);
    rd(`OFS_RES_HI, d); check(d, 8'h03);
    rd(`OFS_RES_LO, d); check(d, 8'hff);
    rd(`OFS_FLAGS, d); check(d, 8'h01);
    rd(`OFS_CTRL0, d); check(d, 8'h15);
    wr(`OFS_FLAGS, 8'h00); rd(`OFS_FLAGS, d); check(d, 8'h00);
    // left justified, then programmed acquisition of four periods
    go(8'h00); settle;
    rd(`OFS_RES_HI, d); check(d, 8'hff);
    rd(`OFS_RES_LO, d); check(d, 8'hc0);
    go(8'h90); settle;
    check((lat - l0 >= 2 && lat - l0 <= 6), 1);
    check(n_conv, 22);
    // abort in mid-conversion keeps the earlier result
    wr(`OFS_FLAGS, 8'h00);
    cmp_i <= 1'b0;
    go(8'h86);
    repeat (150) @(posedge clk_i);
    #1 check(sample_o, 1'b0);
    check(converting_o, 1'b1);
    wr(`OFS_CTRL0, 8'h15); settle;
    rd(`OFS_RES_HI, d); check(d, 8'h03);
    rd(`OFS_FLAGS, d); check(d, 8'h00);
    check((n_dis >= 65 && n_dis <= 129), 1);
    // abort during a long programmed acquisition
    go(8'hbe);
    repeat (40) @(posedge clk_i);
    wr(`OFS_CTRL0, 8'h15); settle;
    check(n_conv, 0);
    rd(`OFS_FLAGS, d); check(d, 8'h00);
    rd(`OFS_RES_LO, d); check(d, 8'hff);
    // sleep with a divider clock kills the conversion
    go(8'h86);
    repeat (100) @(posedge clk_i);
    sleep_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    #1 check(module_on_o, 1'b0);
    check(converting_o, 1'b0);
    rd(`OFS_CTRL0, d); check(d & 8'h01, 8'h01);
    sleep_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    check(module_on_o, 1'b1);
    rd(`OFS_RES_HI, d); check(d, 8'h03);
    // sleep with the rc clock, interrupt enabled then disabled
    wr(`OFS_FLAGS, 8'h02);
    cmp_i <= 1'b1;
    go(8'h83);
    sleep_i <= 1'b1;
    settle;
    check(n_wake, 1);
    check((n_conv >= 105 && n_conv <= 126), 1);
    rd(`OFS_FLAGS, d); check(d, 8'h03);
    sleep_i <= 1'b0;
    wr(`OFS_FLAGS, 8'h00);
    go(8'h83);
    sleep_i <= 1'b1;
    settle;
    repeat (3) @(posedge clk_i);
    #1 check(module_on_o, 1'b0);
    check(n_wake, 0);
    rd(`OFS_CTRL0, d); check(d & 8'h01, 8'h01);
    sleep_i <= 1'b0;
    // special event starts a conversion and pulses the timer reset
    repeat (4) @(posedge clk_i);
    clr;
    special_event_i <= 1'b1;
    @(posedge clk_i);
    special_event_i <= 1'b0;
    #1 check(timer_reset_o, 1'b1);
    settle;
    check(n_tr, 1);
    check((n_conv >= 105 && n_conv <= 126), 1);
    give_verdict;
  end
endmodule
`default_nettype wire
